// ### rtl/edf_ts0_framer.sv
// e1 doubleframe time slot 0 framer with avalon-mm register slave
`include "edf_map.svh"

module edf_ts0_framer (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_line_clk,
  input wire logic rx_line_data,
  input wire logic tx_line_clk,
  input wire logic transmit_system_data_pin,
  input wire logic tx_signaling_pin,
  input wire logic tx_hdlc_queue,
  output logic tx_line_data,
  output logic rx_system_data,
  output logic loss_of_alignment_flag
);
  // ==========================================================================
  // pin synchronisers
  localparam int NPIN = 6;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s2;
  logic rx_clk_d;
  logic tx_clk_d;
  assign pin_raw = {tx_hdlc_queue, tx_signaling_pin, transmit_system_data_pin,
                    tx_line_clk, rx_line_data, rx_line_clk};
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_sync
      always_ff @(posedge mclk)
      begin
        if (!nrst)
        begin
          pin_s1[gi] <= 1'b0;
          pin_s2[gi] <= 1'b0;
        end
        else
        begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      rx_clk_d <= 1'b0;
      tx_clk_d <= 1'b0;
    end
    else
    begin
      rx_clk_d <= pin_s2[0];
      tx_clk_d <= pin_s2[2];
    end
  end

  logic rx_edge;
  logic tx_edge;
  logic rx_d;
  logic sys_d;
  logic sig_d;
  logic hdlc_d;
  assign rx_edge = pin_s2[0] & ~rx_clk_d;
  assign tx_edge = pin_s2[2] & ~tx_clk_d;
  assign rx_d = pin_s2[1];
  assign sys_d = pin_s2[3];
  assign sig_d = pin_s2[4];
  assign hdlc_d = pin_s2[5];

  // ==========================================================================
  // register bus slave, one wait cycle per access
  edf_pkg::edf_ctrl_t ctrl;
  edf_pkg::edf_txsw_t txsw;
  edf_pkg::edf_mask_t mask;
  logic [2:0] evt;
  logic [8:0] rx_sw;
  logic [15:0] framing_error_count;
  logic [7:0] tx_sa [`EDF_NAT_BITS];
  logic [7:0] rx_sa [`EDF_NAT_BITS];
  logic ack;
  logic wr_go;
  logic [31:0] next_rdata;
  logic sa_hit;
  logic [2:0] sa_idx;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_go = avs_write & ack;
  assign sa_idx = avs_address[4:2];
  assign sa_hit = (sa_idx < 3'(`EDF_NAT_BITS)) && (avs_address[1:0] == 2'b00);

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      ack <= 1'b0;
    else
      ack <= (avs_read | avs_write) & ~ack;
  end

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (avs_address)
      `EDF_OFS_CTRL: next_rdata = {20'h0_0000, ctrl};
      `EDF_OFS_TXSW: next_rdata = {24'h00_0000, txsw};
      `EDF_OFS_MASK: next_rdata = {24'h00_0000, mask};
      `EDF_OFS_STAT: next_rdata = {31'h0000_0000, loss_of_alignment_flag};
      `EDF_OFS_EVT: next_rdata = {29'h0000_0000, evt};
      `EDF_OFS_RXSW: next_rdata = {23'h00_0000, rx_sw};
      `EDF_OFS_ERRCNT: next_rdata = {16'h0000, framing_error_count};
      default:
      begin
        if (sa_hit && avs_address[7:5] == `EDF_OFS_TXSA)
          next_rdata = {24'h00_0000, tx_sa[sa_idx]};
        else if (sa_hit && avs_address[7:5] == `EDF_OFS_RXSA)
          next_rdata = {24'h00_0000, rx_sa[sa_idx]};
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read & ~ack)
      avs_readdata <= next_rdata;
  end

  // ==========================================================================
  // receive alignment
  edf_pkg::edf_state_t state;
  logic [7:0] rx_sh;
  logic [7:0] rx_bit;
  logic [3:0] rx_frame;
  logic rx_eval;
  logic ts0_end;
  logic fas_ok;
  logic fas_frame;
  logic [2:0] fas_errs;
  logic [2:0] svc_errs;
  logic [2:0] thr;
  logic ra_prev;
  logic frs_req;
  logic fas_fail;
  logic svc_fail;
  logic drop_sync;
  logic gain_sync;
  logic nfas_bad;

  assign ts0_end = rx_eval && (rx_bit == `EDF_TS0_LAST);
  assign fas_ok = (rx_sh[6:0] == `EDF_FAS_WORD);
  assign fas_frame = ~rx_frame[0];
  assign thr = ctrl.four_error_threshold_sel ? `EDF_THR_HIGH : `EDF_THR_LOW;
  assign fas_fail = ts0_end && fas_frame && !fas_ok;
  assign svc_fail = ts0_end && !fas_frame && !rx_sh[6] && !ctrl.service_check_disable;
  assign drop_sync = (state == edf_pkg::EDF_SYNC) &&
                     (frs_req || (fas_fail && fas_errs == thr - 3'h1) ||
                      (svc_fail && svc_errs == thr - 3'h1));
  assign gain_sync = (state == edf_pkg::EDF_CHK_FAS2) && ts0_end && fas_ok && !nfas_bad;

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      rx_sh <= 8'hFF;
      rx_eval <= 1'b0;
    end
    else
    begin
      rx_eval <= rx_edge;
      if (rx_edge)
        rx_sh <= {rx_sh[6:0], rx_d};
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      rx_bit <= 8'h00;
      rx_frame <= 4'h0;
    end
    else if (rx_edge)
    begin
      rx_bit <= rx_bit + 8'h01;
      if (rx_bit == 8'hFF)
        rx_frame <= rx_frame + 4'h1;
    end
    else if (rx_eval && state == edf_pkg::EDF_HUNT && fas_ok && !frs_req)
    begin
      rx_bit <= `EDF_TS0_LAST;
      rx_frame <= 4'h0;
    end
  end

  // a failed check falls back to hunt at the end of frame n+2 slot 0,
  // so the sliding search resumes only after the frame n+2 word
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      state <= edf_pkg::EDF_HUNT;
    else
    begin
      case (state)
        edf_pkg::EDF_HUNT:
          if (rx_eval && fas_ok && !frs_req)
            state <= edf_pkg::EDF_CHK_NFAS;
        edf_pkg::EDF_CHK_NFAS:
          if (ts0_end)
            state <= edf_pkg::EDF_CHK_FAS2;
        edf_pkg::EDF_CHK_FAS2:
          if (ts0_end)
            state <= (fas_ok && !nfas_bad) ? edf_pkg::EDF_SYNC : edf_pkg::EDF_HUNT;
        edf_pkg::EDF_SYNC:
          if (drop_sync)
            state <= edf_pkg::EDF_HUNT;
        default:
          state <= edf_pkg::EDF_HUNT;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      fas_errs <= 3'h0;
      svc_errs <= 3'h0;
    end
    else if (state != edf_pkg::EDF_SYNC)
    begin
      fas_errs <= 3'h0;
      svc_errs <= 3'h0;
    end
    else if (ts0_end && fas_frame)
      fas_errs <= fas_ok ? 3'h0 : fas_errs + 3'h1;
    else if (ts0_end)
      svc_errs <= svc_fail ? svc_errs + 3'h1 : 3'h0;
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      loss_of_alignment_flag <= 1'b1;
    else if (drop_sync)
      loss_of_alignment_flag <= 1'b1;
    else if (gain_sync)
      loss_of_alignment_flag <= 1'b0;
  end

  // a missed service word is kept so the search resumes only after frame n+2
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      nfas_bad <= 1'b0;
    else if (state == edf_pkg::EDF_CHK_NFAS && ts0_end)
      nfas_bad <= !rx_sh[6];
  end

  // force request waits until alignment is really dropped
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      frs_req <= 1'b0;
    else if (wr_go && avs_address == `EDF_OFS_CTRL && avs_writedata[3])
      frs_req <= 1'b1;
    else if (state == edf_pkg::EDF_HUNT)
      frs_req <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      framing_error_count <= 16'h0000;
    else if (fas_fail && state == edf_pkg::EDF_SYNC && framing_error_count != 16'hFFFF)
      framing_error_count <= framing_error_count + 16'h0001;
  end

  // received words only move while synchronous
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      rx_sw <= `EDF_RXSW_RST;
      ra_prev <= 1'b0;
    end
    else if (ts0_end && state == edf_pkg::EDF_SYNC)
    begin
      if (fas_frame)
        rx_sw[8] <= rx_sh[7];
      else
      begin
        rx_sw[7:0] <= {rx_sh[7:5], rx_sh[0], rx_sh[1], rx_sh[2], rx_sh[3], rx_sh[4]};
        ra_prev <= rx_sh[5];
      end
    end
  end

  generate
    for (gi = 0; gi < `EDF_NAT_BITS; gi++)
    begin : g_rxsa
      always_ff @(posedge mclk)
      begin
        if (!nrst)
          rx_sa[gi] <= `EDF_SA_RST;
        else if (ts0_end && !fas_frame && state == edf_pkg::EDF_SYNC &&
                 ctrl.rx_framing_select == `EDF_RFS_DF16)
          rx_sa[gi][rx_frame[3:1]] <= rx_sh[4 - gi];
      end
    end
  endgenerate

  // sticky events, write one to clear, a new event wins over the clear
  logic [2:0] evt_set;
  assign evt_set[`EDF_EVT_LOST] = drop_sync;
  assign evt_set[`EDF_EVT_RECOV] = gain_sync && ctrl.recov_irq_en;
  assign evt_set[`EDF_EVT_RA] = ts0_end && !fas_frame && state == edf_pkg::EDF_SYNC &&
                                rx_sh[5] && !ra_prev;
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      evt <= 3'h0;
    else if (wr_go && avs_address == `EDF_OFS_EVT)
      evt <= (evt & ~avs_writedata[2:0]) | evt_set;
    else
      evt <= evt | evt_set;
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      rx_system_data <= 1'b1;
    else if (rx_edge)
      rx_system_data <= (loss_of_alignment_flag && !ctrl.backplane_alarm_disable) | rx_d;
  end

  // ==========================================================================
  // control registers
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      ctrl <= `EDF_CTRL_RST;
      txsw <= `EDF_TXSW_RST;
      mask <= `EDF_MASK_RST;
    end
    else if (wr_go)
    begin
      if (avs_address == `EDF_OFS_CTRL)
        ctrl <= {avs_writedata[11:4], 1'b0, avs_writedata[2:0]};
      if (avs_address == `EDF_OFS_TXSW)
        txsw <= avs_writedata[7:0];
      if (avs_address == `EDF_OFS_MASK)
        mask <= avs_writedata[7:0];
    end
  end

  generate
    for (gi = 0; gi < `EDF_NAT_BITS; gi++)
    begin : g_txsa
      always_ff @(posedge mclk)
      begin
        if (!nrst)
          tx_sa[gi] <= `EDF_SA_RST;
        else if (wr_go && sa_hit && avs_address[7:5] == `EDF_OFS_TXSA && sa_idx == 3'(gi))
          tx_sa[gi] <= avs_writedata[7:0];
      end
    end
  endgenerate

  // ==========================================================================
  // transmit slot 0 composition
  logic [7:0] tx_bit;
  logic [3:0] tx_frame;
  logic next_tx_bit;
  logic src_bit;
  logic alarm_bit;
  logic [2:0] tidx;
  logic [2:0] nat_k;
  logic nat_bit;
  localparam logic [6:0] FAS_BITS = `EDF_FAS_WORD;

  assign tidx = tx_bit[2:0];
  assign nat_k = tidx - 3'h3;
  assign alarm_bit = ctrl.auto_remote_alarm_tx ? loss_of_alignment_flag : txsw.send_remote_alarm;
  assign nat_bit = (ctrl.tx_national_regs_enable && ctrl.rx_framing_select == `EDF_RFS_DF16) ?
                   tx_sa[nat_k][tx_frame[3:1]] : txsw.tx_national_bits[nat_k];

  always_comb
  begin
    case (ctrl.ts0_src_sel)
      2'b00: src_bit = sys_d;
      2'b01: src_bit = sig_d;
      default: src_bit = hdlc_d;
    endcase
    next_tx_bit = sys_d;
    if (tx_bit[7:3] == 5'h00)
    begin
      if (ctrl.slot0_full_transparent)
        next_tx_bit = src_bit;
      else if (!tx_frame[0])
      begin
        if (tidx == 3'h0)
          next_tx_bit = mask.intl_bit_passthrough_a ? sys_d : txsw.tx_intl_bit_a;
        else
          next_tx_bit = FAS_BITS[3'h7 - tidx];
      end
      else
      begin
        case (tidx)
          3'h0: next_tx_bit = mask.intl_bit_passthrough_b ? sys_d : txsw.tx_intl_bit_b;
          3'h1: next_tx_bit = 1'b1;
          3'h2: next_tx_bit = mask.alarm_bit_passthrough ? sys_d : alarm_bit;
          default: next_tx_bit = mask.national_bits_passthrough[nat_k] ? sys_d : nat_bit;
        endcase
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      tx_bit <= 8'h00;
      tx_frame <= 4'h0;
      tx_line_data <= 1'b1;
    end
    else if (tx_edge)
    begin
      tx_line_data <= next_tx_bit;
      tx_bit <= tx_bit + 8'h01;
      if (tx_bit == 8'hFF)
        tx_frame <= tx_frame + 4'h1;
    end
  end

  // ==========================================================================
  // checks
  sequence s_sync_left;
    state == edf_pkg::EDF_SYNC ##1 state == edf_pkg::EDF_HUNT;
  endsequence
  sequence s_sync_gained;
    state == edf_pkg::EDF_CHK_FAS2 ##1 state == edf_pkg::EDF_SYNC;
  endsequence

  property p_lost_flag;
    @(posedge mclk) disable iff (!nrst) s_sync_left |-> loss_of_alignment_flag && evt[`EDF_EVT_LOST];
  endproperty
  a_lost_flag: assert property (p_lost_flag) else $error("loss not flagged");

  property p_gain_clear;
    @(posedge mclk) disable iff (!nrst) s_sync_gained |-> !loss_of_alignment_flag;
  endproperty
  a_gain_clear: assert property (p_gain_clear) else $error("loss flag kept");

  property p_sync_path;
    @(posedge mclk) disable iff (!nrst) $changed(state) && state == edf_pkg::EDF_SYNC
      |-> $past(state) == edf_pkg::EDF_CHK_FAS2;
  endproperty
  a_sync_path: assert property (p_sync_path) else $error("sync without checks");

  property p_ais;
    @(posedge mclk) disable iff (!nrst) rx_edge && loss_of_alignment_flag && !ctrl.backplane_alarm_disable
      |=> rx_system_data;
  endproperty
  a_ais: assert property (p_ais) else $error("no all ones");

  property p_errcnt_hold;
    @(posedge mclk) disable iff (!nrst) state != edf_pkg::EDF_SYNC |=> $stable(framing_error_count);
  endproperty
  a_errcnt_hold: assert property (p_errcnt_hold) else $error("error count moved");

  property p_auto_alarm;
    @(posedge mclk) disable iff (!nrst) tx_edge && tx_bit == 8'h02 && tx_frame[0] &&
      ctrl.auto_remote_alarm_tx && !mask.alarm_bit_passthrough && !ctrl.slot0_full_transparent
      |=> tx_line_data == $past(loss_of_alignment_flag);
  endproperty
  a_auto_alarm: assert property (p_auto_alarm) else $error("bad alarm bit");

  property p_fas_tx;
    @(posedge mclk) disable iff (!nrst) tx_edge && tx_bit == 8'h01 && !tx_frame[0] &&
      !ctrl.slot0_full_transparent |=> !tx_line_data;
  endproperty
  a_fas_tx: assert property (p_fas_tx) else $error("fas bit 2 wrong");

  property p_nfas_tx;
    @(posedge mclk) disable iff (!nrst) tx_edge && tx_bit == 8'h01 && tx_frame[0] &&
      !ctrl.slot0_full_transparent |=> tx_line_data;
  endproperty
  a_nfas_tx: assert property (p_nfas_tx) else $error("nfas bit 2 wrong");

  property p_drop;
    @(posedge mclk) disable iff (!nrst) state == edf_pkg::EDF_SYNC && fas_fail && fas_errs == thr - 3'h1
      |=> state == edf_pkg::EDF_HUNT;
  endproperty
  a_drop: assert property (p_drop) else $error("no drop at threshold");

  property p_bus;
    @(posedge mclk) disable iff (!nrst) (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus) else $error("bus stalled");
endmodule : edf_ts0_framer

// ### rtl/edf_map.svh
// register map, field positions, reset values and framing constants of the ts0 framer
`ifndef EDF_MAP_SVH
`define EDF_MAP_SVH
// ==========================================================================
// register byte offsets, and address bits 7:5 selects of the tx and rx sa banks
`define EDF_OFS_CTRL 8'h00
`define EDF_OFS_TXSW 8'h04
`define EDF_OFS_MASK 8'h08
`define EDF_OFS_STAT 8'h0C
`define EDF_OFS_EVT 8'h10
`define EDF_OFS_RXSW 8'h14
`define EDF_OFS_ERRCNT 8'h18
`define EDF_OFS_TXSA 3'h1
`define EDF_OFS_RXSA 3'h2
// ==========================================================================
// reset values
`define EDF_CTRL_RST 12'h800
`define EDF_TXSW_RST 8'hFD
`define EDF_MASK_RST 8'h00
`define EDF_RXSW_RST 9'h1FF
`define EDF_SA_RST 8'hFF
// ==========================================================================
// event bits
`define EDF_EVT_LOST 0
`define EDF_EVT_RECOV 1
`define EDF_EVT_RA 2
// ==========================================================================
// framing constants
`define EDF_FAS_WORD 7'b0011011
`define EDF_TS0_LAST 8'h07
`define EDF_THR_LOW 3'h3
`define EDF_THR_HIGH 3'h4
`define EDF_RFS_DF16 2'b01
`define EDF_NAT_BITS 5
`endif

// ### rtl/edf_pkg.sv
// types shared by the ts0 framer
package edf_pkg;
  typedef enum logic [3:0] {
    EDF_HUNT = 4'b0001,
    EDF_CHK_NFAS = 4'b0010,
    EDF_CHK_FAS2 = 4'b0100,
    EDF_SYNC = 4'b1000
  } edf_state_t;

  typedef struct packed {
    logic recov_irq_en;
    logic [1:0] rx_framing_select;
    logic tx_national_regs_enable;
    logic [1:0] ts0_src_sel;
    logic slot0_full_transparent;
    logic auto_remote_alarm_tx;
    logic force_resync;
    logic backplane_alarm_disable;
    logic service_check_disable;
    logic four_error_threshold_sel;
  } edf_ctrl_t;

  typedef struct packed {
    logic tx_intl_bit_a;
    logic [4:0] tx_national_bits;
    logic send_remote_alarm;
    logic tx_intl_bit_b;
  } edf_txsw_t;

  typedef struct packed {
    logic [4:0] national_bits_passthrough;
    logic alarm_bit_passthrough;
    logic intl_bit_passthrough_b;
    logic intl_bit_passthrough_a;
  } edf_mask_t;
endpackage : edf_pkg

// ### test/edf_line_partner.sv
// remote e1 line equipment model: drives the receive line, watches the transmit line
module edf_line_partner (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic bad_fas,
  input wire logic alarm_a,
  input wire logic [4:0] sa_bits,
  input wire logic tx_line_data,
  output logic line_clk,
  output logic line_data,
  output logic [8:0] bit_no,
  output logic [7:0] tx_window
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] div;
  logic [7:0] word;
  // ==========================================================================
  // slot 0 words; bad_fas spoils the last alignment bit
  always_comb
  begin
    if (!bit_no[8])
      word = {1'b1, 6'b001101, ~bad_fas};
    else
      word = {1'b1, 1'b1, alarm_a, sa_bits};
  end
  // ==========================================================================
  // bit clock of 8 mclk; other slots alternate so no false alignment word appears
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      div <= 3'h0;
      line_clk <= 1'b0;
      line_data <= 1'b1;
      bit_no <= 9'h000;
      tx_window <= 8'h00;
    end
    else
    begin
      div <= div + 3'h1;
      if (div == 3'h3)
      begin
        line_clk <= 1'b1;
        tx_window <= {tx_window[6:0], tx_line_data};
      end
      if (div == 3'h7)
      begin
        line_clk <= 1'b0;
        bit_no <= bit_no + 9'h001;
        line_data <= (bit_no[7:3] == 5'h00) ? word[3'h7 - bit_no[2:0]] : bit_no[0];
      end
    end
  end
endmodule : edf_line_partner

// ### test/e1_doubleframe_ts0_framer_test.sv
// register and line level testbench of the ts0 framer
`include "edf_map.svh"
module e1_doubleframe_ts0_framer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic line_clk, line_data, tx_line_data, rx_system_data, loss_of_alignment_flag, found;
  logic sys_pin = 1'b0;
  logic bad_fas = 1'b1;
  logic alarm_a = 1'b0;
  logic [4:0] sa_bits = 5'b10110;
  logic [8:0] bit_no;
  logic [7:0] tx_window;
  logic [31:0] rd;
  int bad_count = 0;
  int tests_run = 0;
  always #25 mclk = ~mclk;
  // ==========================================================================
  // design and far end
  edf_ts0_framer edf_ts0_framer_inst (.mclk(mclk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_line_clk(line_clk),
    .rx_line_data(line_data), .tx_line_clk(line_clk), .transmit_system_data_pin(sys_pin),
    .tx_signaling_pin(1'b0), .tx_hdlc_queue(1'b0), .tx_line_data(tx_line_data),
    .rx_system_data(rx_system_data), .loss_of_alignment_flag(loss_of_alignment_flag));
  edf_line_partner edf_line_partner_inst (.mclk(mclk), .nrst(nrst), .bad_fas(bad_fas),
    .alarm_a(alarm_a), .sa_bits(sa_bits), .tx_line_data(tx_line_data), .line_clk(line_clk),
    .line_data(line_data), .bit_no(bit_no), .tx_window(tx_window));
  // ==========================================================================
  // tasks
  task automatic tally_and_finish();
    $display("mismatches %0d, compares %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask : chk
  task automatic hang();
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    bad_count++;
    tally_and_finish();
  endtask : hang
  // entered just after a rising edge; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= ~wr;
    avs_write <= wr;
    for (n = 0; n < 20; n++)
    begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    if (n == 20)
      hang();
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdc
  task automatic wait_flag(input logic v);
    int n;
    tests_run++;
    for (n = 0; n < 40000 && loss_of_alignment_flag !== v; n++)
      @(negedge mclk);
    if (n == 40000)
      hang();
    @(posedge mclk);
  endtask : wait_flag
  task automatic scan(input logic [7:0] v, input int lim);
    int n;
    found = 1'b0;
    for (n = 0; n < lim && !found; n++)
    begin
      @(negedge mclk);
      found = (tx_window === v);
    end
    @(posedge mclk);
  endtask : scan
  task automatic expect_tx(input logic [7:0] v);
    scan(v, 9000);
    chk(found, 1'b1);
  endtask : expect_tx
  // ==========================================================================
  // sequence
  initial
  begin
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    rdc(`EDF_OFS_CTRL, `EDF_CTRL_RST);
    rdc(`EDF_OFS_TXSW, `EDF_TXSW_RST);
    rdc(`EDF_OFS_MASK, `EDF_MASK_RST);
    rdc(`EDF_OFS_RXSW, `EDF_RXSW_RST);
    rdc(`EDF_OFS_STAT, 32'h0000_0001);
    bus(1'b1, 8'h7C, 32'hFFFF_FFFF);
    rdc(8'h7C, 32'h0000_0000);
    bus(1'b1, `EDF_OFS_CTRL, 32'h0000_0810);
    expect_tx(8'hFF);
    expect_tx(8'h9B);
    bad_fas <= 1'b0;
    wait_flag(1'b0);
    rdc(`EDF_OFS_EVT, 32'h0000_0002);
    rdc(`EDF_OFS_STAT, 32'h0000_0000);
    expect_tx(8'hDF);
    bus(1'b1, `EDF_OFS_EVT, 32'h0000_0007);
    bus(1'b1, `EDF_OFS_CTRL, 32'h0000_0800);
    bus(1'b1, `EDF_OFS_TXSW, 32'h0000_00FF);
    expect_tx(8'hFF);
    bus(1'b1, `EDF_OFS_MASK, 32'h0000_0004);
    expect_tx(8'hDF);
    bus(1'b1, `EDF_OFS_MASK, 32'h0000_0000);
    bus(1'b1, `EDF_OFS_TXSW, 32'h0000_00FD);
    rdc(`EDF_OFS_RXSW, 32'h0000_01CD);
    // all of slot 0 from a quiet system pin: no alignment word may leave
    bus(1'b1, `EDF_OFS_CTRL, 32'h0000_0820);
    repeat (4200) @(posedge mclk);
    scan(8'h9B, 4500);
    chk(found, 1'b0);
    bus(1'b1, `EDF_OFS_CTRL, 32'h0000_0800);
    alarm_a <= 1'b1;
    repeat (4500) @(posedge mclk);
    rdc(`EDF_OFS_EVT, 32'h0000_0004);
    rdc(`EDF_OFS_RXSW, 32'h0000_01ED);
    alarm_a <= 1'b0;
    bus(1'b1, `EDF_OFS_EVT, 32'h0000_0007);
    // three spoiled words lose alignment, two do not
    for (int i = 0; i < 5000 && bit_no !== 9'd500; i++)
      @(negedge mclk);
    @(posedge mclk);
    bad_fas <= 1'b1;
    repeat (8192) @(negedge mclk);
    chk(loss_of_alignment_flag, 1'b0);
    repeat (1024) @(negedge mclk);
    chk(loss_of_alignment_flag, 1'b1);
    for (int i = 0; i < 16; i++)
    begin
      repeat (7) @(negedge mclk);
      chk(rx_system_data, 1'b1);
    end
    @(posedge mclk);
    rdc(`EDF_OFS_EVT, 32'h0000_0001);
    rdc(`EDF_OFS_ERRCNT, 32'h0000_0003);
    sa_bits <= 5'b00011;
    repeat (5000) @(posedge mclk);
    rdc(`EDF_OFS_RXSW, 32'h0000_01CD);
    rdc(`EDF_OFS_ERRCNT, 32'h0000_0003);
    bad_fas <= 1'b0;
    wait_flag(1'b0);
    // service word moves only at the next non-alignment frame
    repeat (2400) @(posedge mclk);
    rdc(`EDF_OFS_RXSW, 32'h0000_01D8);
    bus(1'b1, `EDF_OFS_EVT, 32'h0000_0007);
    bus(1'b1, `EDF_OFS_CTRL, 32'h0000_0808);
    wait_flag(1'b1);
    wait_flag(1'b0);
    rdc(`EDF_OFS_EVT, 32'h0000_0003);
    rdc(`EDF_OFS_CTRL, 32'h0000_0800);
    bus(1'b1, `EDF_OFS_CTRL, 32'h0000_0B00);
    bus(1'b1, 8'h20, 32'h0000_0000);
    rdc(8'h20, 32'h0000_0000);
    expect_tx(8'hCF);
    tally_and_finish();
  end
endmodule : e1_doubleframe_ts0_framer_test
